//--- verilog/tgo_pkg.sv
// constants and types for the trigger-gated sample output block
// assumes one controller clock of 100 MHz and a separate link clock
package tgo_pkg;

  // controller clock rate
  localparam int CLK_MHZ = 100;

  // channel slots and sample width
  localparam int NCH = 4;
  localparam int CH_W = 3;
  localparam int VAL_W = 24;

  // trigger modes
  localparam int MODE_W = 2;
  localparam logic [1:0] MODE_FREE = 2'h0;
  localparam logic [1:0] MODE_EDGE = 2'h1;
  localparam logic [1:0] MODE_LEVEL = 2'h2;
  localparam logic [1:0] MODE_GATE = 2'h3;

  // chain of synchronised controllers
  localparam int MAX_CHAIN = 8;

  // sync-out pulse: least time, rounded up
  localparam int SYNC_PULSE_NS = 40;
  localparam int SYNC_PULSE_CYC = (SYNC_PULSE_NS * CLK_MHZ + 999) / 1000;

  // loss of upstream sync: longest time, rounded down
  localparam int SYNC_LOSS_NS = 20000;
  localparam int SYNC_LOSS_CYC = SYNC_LOSS_NS * CLK_MHZ / 1000;
  localparam int LOSS_W = 12;

  // data rate divider
  localparam int RATE_W = 16;
  localparam logic [RATE_W-1:0] RATE_DIV_RST = 16'h0064;

  // pending frame counter
  localparam int PEND_W = 4;
  localparam logic [PEND_W-1:0] PEND_MAX = 4'hf;

  // buffering
  localparam int FIFO_DEPTH = 8;

  // one output word: channel number and its value
  typedef struct packed {
    logic [CH_W-1:0] chan;
    logic [VAL_W-1:0] value;
  } tgo_word_t;

  localparam int WORD_W = $bits(tgo_word_t);

  // frame sequencer states
  typedef enum logic {
    TGO_IDLE,
    TGO_SEND
  } tgo_send_st_t;

endpackage

//--- verilog/tgo_trigger_out.sv
// trigger-gated release of per-channel samples onto an output stream
// assumes demodulator data on mclk; stream consumer on its own link_clk
//
// Summary of operation
// - mode 1: one value per channel per edge
// - fast edges resend the latest stored values
// - mode 2: stream while trigger input high
// - mode 3: each rising edge toggles the gate
// - software request sends one frame in any mode while the slot-one demodulator is present
// - up to eight controllers chained by sync
// - slot-one demodulator sets the common cycle
// - sync input slaves the local oscillator
`timescale 1ns/1ps

module tgo_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // honest full and empty from the fill count
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_q];

  // storage, written without reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // tgo_fifo

module tgo_trigger_out
  import tgo_pkg::*;
#(
  parameter int N = NCH,
  parameter int DEPTH = FIFO_DEPTH
) (
  // controller clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // configuration, held steady by the host
  input wire logic trig_en,
  input wire logic [MODE_W-1:0] trig_mode,
  input wire logic [RATE_W-1:0] rate_div,
  input wire logic sw_req,
  // trigger and sync pins
  input wire logic trig_in,
  input wire logic sync_in,
  output logic sync_out,
  // demodulators
  input wire logic demod1_present,
  output logic conv_start,
  input wire logic adc_valid,
  input wire logic [N-1:0][VAL_W-1:0] adc_data,
  // output stream on the link clock
  input wire logic link_clk,
  input wire logic link_reset_n,
  output logic out_valid,
  input wire logic out_ready,
  output tgo_word_t out_word
);

  // trigger pin: two flops, then edge detect
  logic trig_s1_q;
  logic trig_s2_q;
  logic trig_s3_q;
  logic trig_rise;
  logic trig_lvl;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else begin
      trig_s1_q <= trig_in;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end
  assign trig_lvl = trig_s2_q;
  assign trig_rise = trig_s2_q & ~trig_s3_q;

  // sync pin: same two-flop treatment
  logic sync_s1_q;
  logic sync_s2_q;
  logic sync_s3_q;
  logic sync_rise;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sync_s1_q <= 1'b0;
      sync_s2_q <= 1'b0;
      sync_s3_q <= 1'b0;
    end else begin
      sync_s1_q <= sync_in;
      sync_s2_q <= sync_s1_q;
      sync_s3_q <= sync_s2_q;
    end
  end
  assign sync_rise = sync_s2_q & ~sync_s3_q;

  // master or slave: upstream activity takes over the oscillator
  logic slave_q;
  logic [LOSS_W-1:0] loss_q;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      slave_q <= 1'b0;
      loss_q <= '0;
    end else if (sync_rise) begin
      slave_q <= 1'b1;
      loss_q <= '0;
    end else if (loss_q == LOSS_W'(SYNC_LOSS_CYC)) begin
      slave_q <= 1'b0; // upstream gone, run free again
    end else if (slave_q) begin
      loss_q <= loss_q + 1'b1;
    end
  end

  // local oscillator at the data rate
  logic [RATE_W-1:0] rate_q;
  logic cyc_tick;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rate_q <= RATE_DIV_RST;
    end else if (rate_q == '0 || sync_rise) begin
      rate_q <= rate_div - 1'b1; // realign to upstream
    end else begin
      rate_q <= rate_q - 1'b1;
    end
  end

  assign cyc_tick = demod1_present &
                    (slave_q ? sync_rise : (rate_q == '0));

  // conversion start to all channels at once
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= cyc_tick;
    end
  end

  // sync out stretched so a slower downstream catches it
  logic [2:0] spulse_q;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sync_out <= 1'b0;
      spulse_q <= '0;
    end else if (cyc_tick) begin
      sync_out <= 1'b1;
      spulse_q <= 3'(SYNC_PULSE_CYC - 1);
    end else if (spulse_q != '0) begin
      spulse_q <= spulse_q - 1'b1;
    end else begin
      sync_out <= 1'b0;
    end
  end

  // latest converted values per channel
  logic [N-1:0][VAL_W-1:0] latest_q;
  logic fresh_q;
  logic conv_done;

  assign conv_done = adc_valid & demod1_present;

  // fresh marks values not yet sent; edges may reuse old ones
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      latest_q <= '0;
    end else if (conv_done) begin
      latest_q <= adc_data;
    end
  end

  // gate for mode 3
  logic gate_q;

  always_ff @(posedge mclk) begin
    if (!reset_n || !trig_en || trig_mode != MODE_GATE) begin
      gate_q <= 1'b0;
    end else if (trig_rise) begin
      gate_q <= ~gate_q;
    end
  end

  // frame requests
  logic edge_go;
  logic stream_go;
  logic soft_go;
  logic req_any;

  assign edge_go = trig_en & (trig_mode == MODE_EDGE) & trig_rise &
                   demod1_present;
  assign stream_go = conv_done &
                     (~trig_en | (trig_mode == MODE_FREE) |
                      ((trig_mode == MODE_LEVEL) & trig_lvl) |
                      ((trig_mode == MODE_GATE) & gate_q));
  assign soft_go = sw_req & demod1_present;
  assign req_any = edge_go | stream_go | soft_go;

  // frame sequencer
  tgo_send_st_t st_q;
  logic [PEND_W-1:0] pend_q;
  logic [CH_W-1:0] ch_q;
  logic [N-1:0][VAL_W-1:0] snap_q;
  logic start;
  logic push;
  logic push_ready;
  logic last;

  assign start = (st_q == TGO_IDLE) && (pend_q != '0);
  assign push = (st_q == TGO_SEND);
  assign last = (ch_q == CH_W'(N - 1));

  // pending count: a new request in the start cycle still counts
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pend_q <= '0;
    end else if (req_any && !start) begin
      pend_q <= (pend_q == PEND_MAX) ? pend_q : pend_q + 1'b1;
    end else if (start && !req_any) begin
      pend_q <= pend_q - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      snap_q <= '0;
      fresh_q <= 1'b0;
    end else if (start) begin
      snap_q <= latest_q;
      fresh_q <= conv_done;
    end else if (conv_done) begin
      fresh_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_q <= TGO_IDLE;
      ch_q <= '0;
    end else begin
      case (st_q)
        TGO_IDLE: begin
          ch_q <= '0;
          if (start) begin
            st_q <= TGO_SEND;
          end
        end
        TGO_SEND: begin
          if (push_ready) begin
            ch_q <= ch_q + 1'b1;
            if (last) begin
              st_q <= TGO_IDLE;
            end
          end
        end
        default: st_q <= TGO_IDLE;
      endcase
    end
  end

  // fifo between sequencer and crossing; full stalls the walk
  tgo_word_t push_word;
  logic [WORD_W-1:0] pop_data;
  logic pop_valid;
  logic pop_ready;

  assign push_word.chan = ch_q;
  assign push_word.value = snap_q[ch_q];

  tgo_fifo #(.W(WORD_W), .DEPTH(DEPTH)) u_fifo (
    .clk(mclk),
    .reset_n(reset_n),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(push_word),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_data)
  );

  // toggle handshake: one word in flight, slow but safe for any phase
  logic req_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic ack_q;
  logic [WORD_W-1:0] hold_q;

  assign pop_ready = (req_q == ack_s2_q);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      req_q <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      hold_q <= '0;
    end else begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
      if (pop_valid && pop_ready) begin
        hold_q <= pop_data;
        req_q <= ~req_q;
      end
    end
  end

  // link side: capture held word when the toggle arrives
  logic req_s1_q;
  logic req_s2_q;

  always_ff @(posedge link_clk) begin
    if (!link_reset_n) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      ack_q <= 1'b0;
      out_valid <= 1'b0;
      out_word <= '0;
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      if (out_valid && out_ready) begin
        out_valid <= 1'b0;
      end else if (!out_valid && req_s2_q != ack_q) begin
        out_word <= tgo_word_t'(hold_q);
        out_valid <= 1'b1;
        ack_q <= req_s2_q;
      end
    end
  end

  // checks
  property p_trig_sync;
    @(posedge mclk) disable iff (!reset_n)
      trig_rise |-> $past(trig_s1_q, 1) && !$past(trig_s1_q, 2);
  endproperty
  a_trig_sync: assert property (p_trig_sync)
    else $error("trigger edge not from synchronised input");

  property p_edge_frame;
    @(posedge mclk) disable iff (!reset_n)
      (st_q == TGO_IDLE && pend_q == '0 && edge_go)
        |-> ##2 st_q == TGO_SEND && ch_q == '0;
  endproperty
  a_edge_frame: assert property (p_edge_frame)
    else $error("edge did not start a frame at channel zero");

  property p_resend;
    @(posedge mclk) disable iff (!reset_n)
      start |=> snap_q == $past(latest_q);
  endproperty
  a_resend: assert property (p_resend)
    else $error("frame did not carry the latest values");

  // no conversion since the last frame: the same values go out again
  property p_stale_resend;
    @(posedge mclk) disable iff (!reset_n)
      start && !fresh_q |=> snap_q == $past(snap_q);
  endproperty
  a_stale_resend: assert property (p_stale_resend)
    else $error("stale frame did not repeat the previous values");

  property p_level_stop;
    @(posedge mclk) disable iff (!reset_n)
      (trig_en && trig_mode == MODE_LEVEL && !trig_lvl && !sw_req)
        |-> !req_any;
  endproperty
  a_level_stop: assert property (p_level_stop)
    else $error("level mode requested a frame while low");

  property p_gate_toggle;
    @(posedge mclk) disable iff (!reset_n)
      (trig_en && trig_mode == MODE_GATE && trig_rise)
        |=> gate_q != $past(gate_q);
  endproperty
  a_gate_toggle: assert property (p_gate_toggle)
    else $error("gate did not toggle on edge");

  property p_soft;
    @(posedge mclk) disable iff (!reset_n)
      soft_go |=> (pend_q != '0) || (st_q == TGO_SEND);
  endproperty
  a_soft: assert property (p_soft)
    else $error("software request lost");

  property p_sync_pulse;
    @(posedge mclk) disable iff (!reset_n)
      $rose(sync_out) |-> sync_out [*4] ##1 (!sync_out || $past(cyc_tick));
  endproperty
  a_sync_pulse: assert property (p_sync_pulse)
    else $error("sync out pulse width wrong");

  property p_no_demod;
    @(posedge mclk) disable iff (!reset_n)
      !demod1_present |=> !conv_start;
  endproperty
  a_no_demod: assert property (p_no_demod)
    else $error("conversion started without slot-one demodulator");

  property p_slave;
    @(posedge mclk) disable iff (!reset_n)
      slave_q && !sync_rise |-> !cyc_tick;
  endproperty
  a_slave: assert property (p_slave)
    else $error("slave ran its own oscillator");

  property p_out_hold;
    @(posedge link_clk) disable iff (!link_reset_n)
      out_valid && !out_ready |=> out_valid && $stable(out_word);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("output word dropped under back-pressure");

endmodule // tgo_trigger_out

//--- verification/tgo_partner_model.sv
// demodulator and upstream controller model for the trigger output block
// assumes conv_start pulses on mclk; sync pulses only while sync_on is set
`timescale 1ns/1ps
module tgo_partner_model
  import tgo_pkg::*;
(
  // clock and behaviour controls
  input wire logic mclk,
  input wire logic slow,
  input wire logic sync_on,
  // demodulator side
  input wire logic conv_start,
  output logic adc_valid,
  output logic [NCH-1:0][VAL_W-1:0] adc_data,
  // upstream sync pin
  output logic sync_in
);
  int dly = -1;
  int cyc = 0;
  logic [15:0] cnt = 16'h0000;
  logic fire = 1'b0;

  initial begin
    adc_valid = 1'b0;
    adc_data = '0;
    sync_in = 1'b0;
  end

  // one conversion fills all lanes
  // data flips every cycle outside the valid cycle, so stale values equal the last valid ones every second cycle
  always @(posedge mclk) begin
    fire = 1'b0;
    if (conv_start) begin
      dly = slow ? 12 : 3;
    end else if (dly > 0) begin
      dly = dly - 1;
    end else if (dly == 0) begin
      dly = -1;
      cnt = cnt + 16'h0001;
      fire = 1'b1;
    end
    // one assignment per lane per edge
    adc_valid <= fire;
    for (int c = 0; c < NCH; c++) begin
      adc_data[c] <= fire ? {8'(c), cnt} : ~adc_data[c];
    end
  end

  always @(posedge mclk) begin
    cyc = (cyc == 59) ? 0 : cyc + 1;
    sync_in <= sync_on && (cyc < 4);
  end
endmodule // tgo_partner_model

//--- verification/testbench.sv
// self-checking bench for the trigger-gated sample output block
// assumes the partner model answers conversions and feeds sync_in
`timescale 1ns/1ps
module testbench;
  import tgo_pkg::*;
  logic mclk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic link_reset_n = 1'b0;
  logic trig_en = 1'b1;
  logic [MODE_W-1:0] trig_mode = MODE_EDGE;
  logic [RATE_W-1:0] rate_div = 16'h0014;
  logic sw_req = 1'b0;
  logic trig_in = 1'b0;
  logic demod1_present = 1'b1;
  logic out_ready = 1'b0;
  logic slow = 1'b0;
  logic sync_on = 1'b0;
  logic sync_in, sync_out, conv_start, adc_valid, out_valid, sin_q, sout_q;
  logic [NCH-1:0][VAL_W-1:0] adc_data;
  tgo_word_t out_word;
  logic [15:0] frame_cnt;
  int seed = 32'h0217;
  int bad_count = 0;
  int check_count = 0;
  int rx_n = 0;
  int sin_n = 0;
  int sout_n = 0;
  int conv_n = 0;

  // clocks, link clock slower (12 ns period) and offset in phase
  always #5 mclk = ~mclk;
  initial #2.5 forever #6 link_clk = ~link_clk;

  tgo_trigger_out i_tgo_trigger_out (.mclk(mclk), .reset_n(reset_n),
    .trig_en(trig_en), .trig_mode(trig_mode), .rate_div(rate_div),
    .sw_req(sw_req), .trig_in(trig_in), .sync_in(sync_in),
    .sync_out(sync_out), .demod1_present(demod1_present),
    .conv_start(conv_start), .adc_valid(adc_valid), .adc_data(adc_data),
    .link_clk(link_clk), .link_reset_n(link_reset_n),
    .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word));

  tgo_partner_model i_tgo_partner_model (.mclk(mclk), .slow(slow),
    .sync_on(sync_on), .conv_start(conv_start), .adc_valid(adc_valid),
    .adc_data(adc_data), .sync_in(sync_in));

  task automatic check_cnt(input int got, input int lo, input int hi,
                           input string what);
    check_count++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("MISMATCH t=%0t %s: %0d not in %0d..%0d", $time, what, got,
               lo, hi);
    end
  endtask

  task automatic check_field(input logic [15:0] got,
                             input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s: %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // pulses of 2..4 cycles keep the pin above its synchroniser minimum
  task automatic pulse(input int hi);
    trig_in <= 1'b1;
    cyc(hi);
    trig_in <= 1'b0;
    cyc(hi);
  endtask

  // drain the stream, then count whole frames since base
  task automatic frames(inout int base, input int lo, input int hi,
                        input string what);
    cyc(1500);
    check_cnt((rx_n - base) / NCH, lo, hi, what);
    check_cnt((rx_n - base) % NCH, 0, 0, what);
    $display("test %s done", what);
    base = rx_n;
  endtask

  // link consumer with random stalls; words checked as taken
  always @(posedge link_clk) begin
    out_ready <= link_reset_n && ($random(seed) % 4 != 0);
    if (out_valid && out_ready) begin
      if (out_word.chan == 3'h0) frame_cnt = out_word.value[15:0];
      check_field(16'(out_word.chan), 16'(rx_n % NCH), "order");
      check_field(16'(out_word.value[23:16]), 16'(out_word.chan),
                  "lane");
      check_field(out_word.value[15:0], frame_cnt, "coherence");
      rx_n++;
    end
  end

  // edge counters for the sync chain
  always @(posedge mclk) begin
    sin_q <= sync_in;
    sout_q <= sync_out;
    if (sync_in && !sin_q) sin_n++;
    if (sync_out && !sout_q) sout_n++;
    if (conv_start) conv_n++;
  end

  initial begin
    int base;
    int s;
    cyc(20);
    reset_n <= 1'b1;
    @(posedge link_clk) link_reset_n <= 1'b1;
    // wait for the first conversion, so no frame carries reset zeros
    cyc(130);
    base = rx_n;
    repeat (5) begin
      pulse(2 + $unsigned($random(seed)) % 3);
      cyc(40 + $unsigned($random(seed)) % 60);
    end
    frames(base, 5, 5, "edge");
    rate_div <= 16'h0190;
    slow <= 1'b1;
    repeat (4) begin
      pulse(2);
      cyc(56);
    end
    frames(base, 4, 4, "resend");
    for (int m = 1; m < 4; m++) begin
      trig_mode <= m[1:0];
      sw_req <= 1'b1;
      cyc(1);
      sw_req <= 1'b0;
      frames(base, 1, 1, "software");
    end
    rate_div <= 16'h0032;
    slow <= 1'b0;
    // let the slow divider run out and reload at the new rate
    cyc(450);
    trig_mode <= MODE_LEVEL;
    trig_in <= 1'b1;
    cyc(500);
    trig_in <= 1'b0;
    frames(base, 9, 11, "level");
    frames(base, 0, 0, "level off");
    trig_mode <= MODE_GATE;
    pulse(3);
    cyc(494);
    pulse(3);
    frames(base, 9, 12, "gate");
    frames(base, 0, 0, "gate off");
    trig_en <= 1'b0;
    cyc(250);
    trig_en <= 1'b1;
    trig_mode <= MODE_FREE;
    cyc(250);
    trig_mode <= MODE_GATE;
    frames(base, 9, 11, "free run");
    trig_mode <= MODE_EDGE;
    demod1_present <= 1'b0;
    pulse(2);
    sw_req <= 1'b1;
    cyc(1);
    sw_req <= 1'b0;
    frames(base, 0, 0, "no demod");
    demod1_present <= 1'b1;
    rate_div <= 16'h00c8;
    cyc(10);
    s = sin_n;
    base = sout_n;
    conv_n = 0;
    sync_on <= 1'b1;
    cyc(600);
    sync_on <= 1'b0;
    cyc(20);
    check_cnt(sout_n - base, sin_n - s - 1, sin_n - s, "sync out");
    check_cnt(conv_n, sin_n - s - 1, sin_n - s + 1, "slave");
    $display("test sync done");
    test_done();
  end

  // watchdog well beyond the expected run
  initial begin
    cyc(60000);
    bad_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    test_done();
  end
endmodule // testbench
